// [hw/ale_exec.sv]
// Purpose: Executes add, AND and bit instructions written over Wishbone
// Assumes: Classic Wishbone slave, synchronous active-high reset, 20 MHz clock
// Notes: An instruction write is acknowledged only when its execution has ended
`timescale 1ns/1ps
`include "ale_params.svh"
module ale_exec
    import ale_pkg::*;
#(
    parameter int PRESC_DIV = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] port_pins_i,
    output logic [7:0] port_latch_o,
    output logic skip_o
);
    ale_state_t state_ff;
    ale_state_t nxt_state;
    logic [13:0] instr_ff;
    logic [7:0] acc_ff;
    logic c_ff;
    logic dc_ff;
    logic z_ff;
    logic skip_ff;
    logic unsup_ff;
    logic psa_ff;
    logic [7:0] tick_ff;
    logic [7:0] presc_ff;
    logic [7:0] latch_ff;
    logic [31:0] dat_ff;

    logic req;
    logic reg_wr;
    logic in_exec;
    ale_op_t op;
    logic [6:0] fsel;
    logic dsel;
    logic [7:0] mem_rdata;
    logic [7:0] file_val;
    logic wr_acc;
    logic wr_file;
    logic upd_cdc;
    logic upd_z;
    logic take_skip;
    logic tick_wr;
    logic presc_wrap;

    ale_alu_if alu_bus ();

    initial begin
        if (PRESC_DIV < 1 || PRESC_DIV > 256) begin
            $error("ale_exec: PRESC_DIV must be 1 to 256");
        end
    end

    function automatic ale_op_t decode(input logic [13:0] ins);
        ale_op_t o;
        o = OP_NONE;
        if (ins[13:12] == `ALE_CLS_BYTE && ins[11:8] == `ALE_SUB_ADDF) begin
            o = OP_ADD_FILE;
        end else if (ins[13:12] == `ALE_CLS_BYTE && ins[11:8] == `ALE_SUB_ANDF) begin
            o = OP_AND_FILE;
        end else if (ins[13:12] == `ALE_CLS_BIT && ins[11:10] == `ALE_BIT_CLR) begin
            o = OP_CLR_BIT;
        end else if (ins[13:12] == `ALE_CLS_BIT && ins[11:10] == `ALE_BIT_SET) begin
            o = OP_SET_BIT;
        end else if (ins[13:12] == `ALE_CLS_BIT && ins[11:10] == `ALE_BIT_TSTL) begin
            o = OP_TEST_BIT;
        end else if (ins[13:12] == `ALE_CLS_LIT && ins[11:9] == `ALE_LIT_ADD) begin
            o = OP_ADD_IMM;
        end else if (ins[13:12] == `ALE_CLS_LIT && ins[11:8] == `ALE_LIT_AND) begin
            o = OP_AND_IMM;
        end
        return o;
    endfunction : decode

    assign req = wb_cyc_i && wb_stb_i && (state_ff == ST_IDLE);
    assign reg_wr = req && wb_we_i && wb_sel_i[0];
    assign in_exec = (state_ff == ST_EXEC);
    assign op = decode(instr_ff);
    assign fsel = instr_ff[6:0];
    assign dsel = instr_ff[7];

    ale_file #(
        .DEPTH(128)
    ) u_file (
        .clk_i(clk_i),
        .raddr_i(fsel),
        .rdata_o(mem_rdata),
        .wen_i(in_exec && wr_file && fsel != `ALE_F_TICK && fsel != `ALE_F_PORT),
        .waddr_i(fsel),
        .wdata_i(alu_bus.res)
    );

    // Port reads see the pins, so a modify-write stores the pin level
    always_comb begin
        if (fsel == `ALE_F_TICK) begin
            file_val = tick_ff;
        end else if (fsel == `ALE_F_PORT) begin
            file_val = port_pins_i;
        end else begin
            file_val = mem_rdata;
        end
    end

    assign alu_bus.op = op;
    assign alu_bus.acc = acc_ff;
    assign alu_bus.opnd = (op == OP_ADD_IMM || op == OP_AND_IMM) ? instr_ff[7:0] : file_val;
    assign alu_bus.bsel = instr_ff[9:7];

    ale_alu u_alu (
        .bus(alu_bus)
    );

    always_comb begin
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_cdc = 1'b0;
        upd_z = 1'b0;
        case (op)
            OP_ADD_IMM: begin
                wr_acc = 1'b1;
                upd_cdc = 1'b1;
                upd_z = 1'b1;
            end
            OP_AND_IMM: begin
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            OP_ADD_FILE: begin
                wr_acc = !dsel;
                wr_file = dsel;
                upd_cdc = 1'b1;
                upd_z = 1'b1;
            end
            OP_AND_FILE: begin
                wr_acc = !dsel;
                wr_file = dsel;
                upd_z = 1'b1;
            end
            OP_CLR_BIT, OP_SET_BIT: begin
                wr_file = 1'b1;
            end
            default: begin
                wr_file = 1'b0;
            end
        endcase
    end

    assign take_skip = in_exec && (op == OP_TEST_BIT) && !alu_bus.bitval;
    assign tick_wr = in_exec && wr_file && (fsel == `ALE_F_TICK);
    assign presc_wrap = psa_ff && (presc_ff == 8'(PRESC_DIV - 1));
    assign skip_o = take_skip;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req && wb_we_i && wb_adr_i == `ALE_ADR_INSTR && wb_sel_i[1:0] == 2'h3) begin
                    nxt_state = ST_EXEC;
                end else if (req) begin
                    nxt_state = ST_ACK;
                end
            end
            ST_EXEC: begin
                // A discarded follower costs one extra cycle
                nxt_state = take_skip ? ST_NOP : ST_ACK;
            end
            ST_NOP: begin
                nxt_state = ST_ACK;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_ff <= 14'h0000;
        end else if (req && nxt_state == ST_EXEC) begin
            instr_ff <= wb_dat_i[13:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= `ALE_RST_ACC;
        end else if (in_exec && wr_acc) begin
            acc_ff <= alu_bus.res;
        end else if (reg_wr && wb_adr_i == `ALE_ADR_ACC) begin
            acc_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_ff <= 1'b0;
            dc_ff <= 1'b0;
            z_ff <= 1'b0;
        end else if (in_exec) begin
            if (upd_cdc) begin
                c_ff <= alu_bus.carry;
                dc_ff <= alu_bus.half;
            end
            if (upd_z) begin
                z_ff <= alu_bus.zero;
            end
        end else if (reg_wr && wb_adr_i == `ALE_ADR_STATUS) begin
            c_ff <= wb_dat_i[`ALE_ST_C];
            dc_ff <= wb_dat_i[`ALE_ST_DC];
            z_ff <= wb_dat_i[`ALE_ST_Z];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_ff <= 1'b0;
            unsup_ff <= 1'b0;
        end else if (in_exec) begin
            skip_ff <= take_skip;
            unsup_ff <= (op == OP_NONE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psa_ff <= `ALE_RST_PSA;
        end else if (reg_wr && wb_adr_i == `ALE_ADR_CONFIG) begin
            psa_ff <= wb_dat_i[`ALE_CFG_PSA];
        end
    end

    // Prescaler clear on a counter write keeps the first new tick a full period away
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_ff <= 8'h00;
        end else if ((tick_wr && psa_ff) || !psa_ff || presc_wrap) begin
            presc_ff <= 8'h00;
        end else begin
            presc_ff <= presc_ff + 8'h01;
        end
    end

    // Without the prescaler the counter advances every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_ff <= 8'h00;
        end else if (tick_wr) begin
            tick_ff <= alu_bus.res;
        end else if (presc_wrap || !psa_ff) begin
            tick_ff <= tick_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_ff <= `ALE_RST_LATCH;
        end else if (in_exec && wr_file && fsel == `ALE_F_PORT) begin
            latch_ff <= alu_bus.res;
        end else if (reg_wr && wb_adr_i == `ALE_ADR_LATCH) begin
            latch_ff <= wb_dat_i[7:0];
        end
    end

    assign port_latch_o = latch_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h00000000;
        end else if (req) begin
            if (wb_we_i) begin
                dat_ff <= 32'h00000000;
            end else if (wb_adr_i == `ALE_ADR_ACC) begin
                dat_ff <= {24'h000000, acc_ff};
            end else if (wb_adr_i == `ALE_ADR_STATUS) begin
                dat_ff <= {27'h0000000, unsup_ff, skip_ff, z_ff, dc_ff, c_ff};
            end else if (wb_adr_i == `ALE_ADR_TICK) begin
                dat_ff <= {24'h000000, tick_ff};
            end else if (wb_adr_i == `ALE_ADR_CONFIG) begin
                dat_ff <= {31'h00000000, psa_ff};
            end else if (wb_adr_i == `ALE_ADR_LATCH) begin
                dat_ff <= {24'h000000, latch_ff};
            end else if (wb_adr_i == `ALE_ADR_PRESC) begin
                dat_ff <= {24'h000000, presc_ff};
            end else begin
                dat_ff <= 32'h00000000;
            end
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = (state_ff == ST_ACK);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_imm_add_result: assert property (
        in_exec && op == OP_ADD_IMM |=>
            acc_ff == $past(acc_ff) + $past(instr_ff[7:0]) && z_ff == (acc_ff == 8'h00))
        else $error("immediate add result or zero flag wrong");

    a_and_only_zero: assert property (
        in_exec && (op == OP_AND_IMM || op == OP_AND_FILE) |=>
            $stable(c_ff) && $stable(dc_ff) && z_ff == $past(alu_bus.zero))
        else $error("AND touched carry flags or missed zero");

    a_add_carry_flags: assert property (
        in_exec && op == OP_ADD_FILE |=>
            c_ff == (({1'b0, $past(acc_ff)} + {1'b0, $past(file_val)}) > 9'h0FF)
            && dc_ff == (({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(file_val[3:0])}) > 5'h0F))
        else $error("add carry or half carry wrong");

    a_bit_flags_keep: assert property (
        in_exec && (op == OP_CLR_BIT || op == OP_SET_BIT) |=>
            $stable(c_ff) && $stable(dc_ff) && $stable(z_ff) && $stable(acc_ff))
        else $error("bit operation changed flags or acc");

    a_bit_write_value: assert property (
        in_exec && (op == OP_CLR_BIT || op == OP_SET_BIT) |->
            alu_bus.res[alu_bus.bsel] == (op == OP_SET_BIT)
            && (alu_bus.res | (8'h01 << alu_bus.bsel)) == (file_val | (8'h01 << alu_bus.bsel)))
        else $error("bit operation wrote wrong value");

    a_dest_select_acc: assert property (
        in_exec && (op == OP_ADD_FILE || op == OP_AND_FILE) && dsel |=> $stable(acc_ff))
        else $error("file destination changed acc");

    a_skip_two_cycle: assert property (
        in_exec && op == OP_TEST_BIT && !alu_bus.bitval |=>
            state_ff == ST_NOP && !wb_ack_o ##1 wb_ack_o)
        else $error("taken skip not two cycles");

    a_no_skip_one: assert property (
        in_exec && op != OP_TEST_BIT |=> wb_ack_o && !skip_ff)
        else $error("plain instruction did not finish in one cycle");

    a_tick_presc_clear: assert property (
        tick_wr && psa_ff |=> presc_ff == 8'h00 && tick_ff == $past(alu_bus.res))
        else $error("counter write did not clear prescaler");

    a_port_pin_read: assert property (
        in_exec && op == OP_SET_BIT && fsel == `ALE_F_PORT |=>
            latch_ff == ($past(port_pins_i) | (8'h01 << $past(instr_ff[9:7]))))
        else $error("port rewrite did not use pin levels");

    c_skip_taken: cover property (in_exec && take_skip ##1 state_ff == ST_NOP);
    c_port_modify: cover property (in_exec && wr_file && fsel == `ALE_F_PORT);
    c_add_carry: cover property (in_exec && op == OP_ADD_IMM && alu_bus.carry);
    c_tick_write: cover property (tick_wr && psa_ff);

endmodule : ale_exec

// [hw/ale_params.svh]
// Purpose: Offsets, field positions, reset values and opcode patterns of the executor
// Assumes: Included by its bare name wherever a constant is needed
// Notes: Definitions only
//
// Summary of operation
// - Read-modify-write of the port register uses pin levels, not the output latch.
// - Writing the tick counter clears the prescaler when it is assigned to the timer.
// - Program-counter change or true conditional test takes two cycles, second a no-op.
// - Immediate add puts acc plus 8-bit literal in acc; updates carry, half carry, zero.
// - Bit clear forces bit b of file f to zero; flags and other bits kept.
// - Bit set forces bit b of file f to one; flags and other bits kept.
// - File add sums acc and file f into destination; updates carry, half carry, zero.
// - Destination select zero writes acc; one writes back to the source file register.
// - Immediate AND puts acc AND literal in acc; updates only the zero flag.
// - Skip-when-low test: bit one continues; bit zero discards next, runs no-op, two cycles.
// - File AND writes acc AND file f to destination; updates only the zero flag.
`ifndef ALE_PARAMS_SVH
`define ALE_PARAMS_SVH

// Wishbone byte addresses
`define ALE_ADR_INSTR 8'h00
`define ALE_ADR_ACC 8'h04
`define ALE_ADR_STATUS 8'h08
`define ALE_ADR_TICK 8'h0C
`define ALE_ADR_CONFIG 8'h10
`define ALE_ADR_LATCH 8'h14
`define ALE_ADR_PRESC 8'h18

// Status and config field positions
`define ALE_ST_C 0
`define ALE_ST_DC 1
`define ALE_ST_Z 2
`define ALE_ST_SKIP 3
`define ALE_ST_UNSUP 4
`define ALE_CFG_PSA 0

// Reset values
`define ALE_RST_ACC 8'h00
`define ALE_RST_LATCH 8'h00
`define ALE_RST_PSA 1'b1

// Special file addresses
`define ALE_F_TICK 7'h01
`define ALE_F_PORT 7'h06

// Opcode patterns
`define ALE_CLS_BYTE 2'h0
`define ALE_CLS_BIT 2'h1
`define ALE_CLS_LIT 2'h3
`define ALE_SUB_ADDF 4'h7
`define ALE_SUB_ANDF 4'h5
`define ALE_BIT_CLR 2'h0
`define ALE_BIT_SET 2'h1
`define ALE_BIT_TSTL 2'h2
`define ALE_LIT_ADD 3'h7
`define ALE_LIT_AND 4'h9

`endif

// [hw/ale_pkg.sv]
// Purpose: Types shared by the executor modules
// Assumes: Constants live in ale_params.svh
// Notes: Types only
package ale_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD_IMM,
        OP_AND_IMM,
        OP_ADD_FILE,
        OP_AND_FILE,
        OP_CLR_BIT,
        OP_SET_BIT,
        OP_TEST_BIT
    } ale_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_NOP,
        ST_ACK
    } ale_state_t;

endpackage : ale_pkg

// [hw/ale_alu_if.sv]
// Purpose: Operands and results between the executor core and its ALU
// Assumes: Single clock domain, purely combinational path
// Notes: Core drives operands, ALU drives results
`timescale 1ns/1ps
interface ale_alu_if;
    import ale_pkg::*;
    ale_op_t op;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [2:0] bsel;
    logic [7:0] res;
    logic carry;
    logic half;
    logic zero;
    logic bitval;
    modport core (output op, acc, opnd, bsel, input res, carry, half, zero, bitval);
    modport alu (input op, acc, opnd, bsel, output res, carry, half, zero, bitval);
endinterface : ale_alu_if

// [hw/ale_alu.sv]
// Purpose: Combinational arithmetic, logic and bit operations
// Assumes: opnd holds the literal for immediate ops and the file value otherwise
// Notes: Flags are computed for every op; the core decides which ones land
`timescale 1ns/1ps
module ale_alu
    import ale_pkg::*;
(
    ale_alu_if.alu bus
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] mask;

    always_comb begin
        sum = {1'b0, bus.acc} + {1'b0, bus.opnd};
        low_sum = {1'b0, bus.acc[3:0]} + {1'b0, bus.opnd[3:0]};
        mask = 8'h01 << bus.bsel;
        case (bus.op)
            OP_ADD_IMM, OP_ADD_FILE: bus.res = sum[7:0];
            OP_AND_IMM, OP_AND_FILE: bus.res = bus.acc & bus.opnd;
            OP_CLR_BIT: bus.res = bus.opnd & ~mask;
            OP_SET_BIT: bus.res = bus.opnd | mask;
            default: bus.res = bus.opnd;
        endcase
        bus.carry = sum[8];
        bus.half = low_sum[4];
        bus.zero = (bus.res == 8'h00);
        bus.bitval = bus.opnd[bus.bsel];
    end
endmodule : ale_alu

// [hw/ale_file.sv]
// Purpose: General-purpose file register storage
// Assumes: Special addresses are intercepted by the core
// Notes: Asynchronous read so an instruction completes in one execute cycle
`timescale 1ns/1ps
module ale_file #(
    parameter int DEPTH = 128
) (
    input wire logic clk_i,
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire logic wen_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i
);
    logic [7:0] mem_ff [DEPTH];

    initial begin
        if (DEPTH < 1 || DEPTH > 128) begin
            $error("ale_file: DEPTH must be 1 to 128");
        end
    end

    // No reset: file contents are undefined at power-up, as in the core
    always_ff @(posedge clk_i) begin
        if (wen_i && (int'(waddr_i) < DEPTH)) begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = (int'(raddr_i) < DEPTH) ? mem_ff[raddr_i] : 8'h00;
endmodule : ale_file

// [tb/test_arith_logic_bit_instr_exec.sv]
// Purpose: Self-checking bench for the add, AND and bit instruction executor
// Assumes: ale_exec top, classic Wishbone register access, 20 MHz clock
// Notes: Reset values first, then table rows, port, prescaler and refusal cases, then reset again
`timescale 1ns/1ps
`include "ale_params.svh"
module test_arith_logic_bit_instr_exec;
    typedef struct {
        logic [7:0] fv;
        logic [7:0] acc;
        logic [3:0] st;
        logic [13:0] op;
        logic [7:0] eacc;
        logic [7:0] efile;
        logic [3:0] est;
    } ale_row_t;
    localparam logic [6:0] FA = 7'h20;
    localparam logic [3:0] ADDK = {`ALE_LIT_ADD, 1'b0};
    localparam logic [3:0] ADDK1 = {`ALE_LIT_ADD, 1'b1};
    logic clk_i, rst_i, cyc, stb, we, skip_o, skip_seen;
    logic [7:0] adr, port_pins_i, port_latch_o;
    logic [3:0] sel;
    logic [31:0] dat_w, wb_dat_o, rd;
    logic wb_ack_o;
    logic [7:0] ps [2];
    int err_count, n_compared, n;
    ale_row_t rows [15];

    ale_exec #(.PRESC_DIV(4)) ale_exec_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pins_i(port_pins_i),
        .port_latch_o(port_latch_o), .skip_o(skip_o));

    function automatic logic [13:0] fop(input logic [3:0] s, input logic d, input logic [6:0] f);
        return {`ALE_CLS_BYTE, s, d, f};
    endfunction : fop
    function automatic logic [13:0] bop(input logic [1:0] k, input logic [2:0] b, input logic [6:0] f);
        return {`ALE_CLS_BIT, k, b, f};
    endfunction : bop
    function automatic logic [13:0] lop(input logic [3:0] h, input logic [7:0] k);
        return {`ALE_CLS_LIT, h, k};
    endfunction : lop

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Request held until ack is sampled; skip_o is watched on every edge of the wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        n = 0;
        skip_seen = 1'b0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
            if (skip_o === 1'b1) skip_seen = 1'b1;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) check("ack wait", 32'h0, 32'h1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask : wr
    task automatic ex(input logic [13:0] op);
        xfer(1'b1, `ALE_ADR_INSTR, {18'h0, op}, 4'h3);
    endtask : ex
    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hF);
        check(nm, rd, e);
    endtask : expect_reg

    // File memory has no reset, so clear it by AND with zero before adding the value
    task automatic load_file(input logic [6:0] f, input logic [7:0] v);
        wr(`ALE_ADR_ACC, 32'h0);
        ex(fop(`ALE_SUB_ANDF, 1'b1, f));
        wr(`ALE_ADR_ACC, {24'h0, v});
        ex(fop(`ALE_SUB_ADDF, 1'b1, f));
    endtask : load_file
    task automatic read_file(input logic [6:0] f);
        wr(`ALE_ADR_ACC, 32'h0);
        ex(fop(`ALE_SUB_ADDF, 1'b0, f));
        xfer(1'b0, `ALE_ADR_ACC, 32'h0, 4'hF);
    endtask : read_file
    task automatic reset_regs;
        expect_reg("rst acc", `ALE_ADR_ACC, 32'h0);
        expect_reg("rst status", `ALE_ADR_STATUS, 32'h0);
        expect_reg("rst config", `ALE_ADR_CONFIG, 32'h1);
        expect_reg("rst latch", `ALE_ADR_LATCH, 32'h0);
    endtask : reset_regs

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        #2000000;
        err_count++;
        results();
    end

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0;
        port_pins_i = 8'h00;
        err_count = 0;
        n_compared = 0;
        rows = '{
            '{8'h00, 8'h0F, 4'h0, lop(ADDK, 8'h01), 8'h10, 8'h00, 4'h2},
            '{8'h00, 8'hFF, 4'h0, lop(ADDK, 8'h01), 8'h00, 8'h00, 4'h7},
            '{8'h00, 8'h80, 4'h0, lop(ADDK1, 8'hFF), 8'h7F, 8'h00, 4'h1},
            '{8'h00, 8'hF0, 4'h3, lop(`ALE_LIT_AND, 8'h0F), 8'h00, 8'h00, 4'h7},
            '{8'h00, 8'hFF, 4'h5, lop(`ALE_LIT_AND, 8'h3C), 8'h3C, 8'h00, 4'h1},
            '{8'h28, 8'h08, 4'h0, fop(`ALE_SUB_ADDF, 1'b0, FA), 8'h30, 8'h28, 4'h2},
            '{8'h80, 8'h80, 4'h0, fop(`ALE_SUB_ADDF, 1'b1, FA), 8'h80, 8'h00, 4'h5},
            '{8'h55, 8'hAA, 4'h3, fop(`ALE_SUB_ANDF, 1'b0, FA), 8'h00, 8'h55, 4'h7},
            '{8'hF3, 8'h3F, 4'h7, fop(`ALE_SUB_ANDF, 1'b1, FA), 8'h3F, 8'h33, 4'h3},
            '{8'hFF, 8'h12, 4'h5, bop(`ALE_BIT_CLR, 3'h7, FA), 8'h12, 8'h7F, 4'h5},
            '{8'h01, 8'h00, 4'h0, bop(`ALE_BIT_CLR, 3'h0, FA), 8'h00, 8'h00, 4'h0},
            '{8'h00, 8'h34, 4'h4, bop(`ALE_BIT_SET, 3'h0, FA), 8'h34, 8'h01, 4'h4},
            '{8'h7F, 8'h00, 4'h2, bop(`ALE_BIT_SET, 3'h7, FA), 8'h00, 8'hFF, 4'h2},
            '{8'h08, 8'h00, 4'h1, bop(`ALE_BIT_TSTL, 3'h3, FA), 8'h00, 8'h08, 4'h1},
            '{8'hF7, 8'h00, 4'h0, bop(`ALE_BIT_TSTL, 3'h3, FA), 8'h00, 8'hF7, 4'h8}};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_regs();
        check("latch pins", port_latch_o, 8'h00);
        foreach (rows[i]) begin
            load_file(FA, rows[i].fv);
            wr(`ALE_ADR_STATUS, {28'h0, rows[i].st});
            wr(`ALE_ADR_ACC, {24'h0, rows[i].acc});
            ex(rows[i].op);
            check("cycles", n, rows[i].est[3] ? 4 : 3);
            check("skip_o", skip_seen, rows[i].est[3]);
            expect_reg("acc", `ALE_ADR_ACC, rows[i].eacc);
            expect_reg("status", `ALE_ADR_STATUS, rows[i].est);
            read_file(FA);
            check("file", rd, rows[i].efile);
        end
        // Latch all ones but pins 7 to 4 low: read-modify-write must take the pins
        wr(`ALE_ADR_LATCH, 32'hFF);
        port_pins_i <= 8'h0F;
        ex(bop(`ALE_BIT_SET, 3'h4, `ALE_F_PORT));
        check("latch set", port_latch_o, 8'h1F);
        port_pins_i <= 8'hAA;
        ex(bop(`ALE_BIT_CLR, 3'h1, `ALE_F_PORT));
        expect_reg("latch clr", `ALE_ADR_LATCH, 32'hA8);
        port_pins_i <= 8'h00;
        ex(bop(`ALE_BIT_TSTL, 3'h3, `ALE_F_PORT));
        check("pin test", n, 4);
        // Same sequence at two phases: a counter write must realign the prescaler
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 2; j++) begin
                repeat (j) @(posedge clk_i);
                wr(`ALE_ADR_ACC, 32'h0);
                ex(fop(`ALE_SUB_ANDF, k[0], `ALE_F_TICK));
                xfer(1'b0, `ALE_ADR_PRESC, 32'h0, 4'hF);
                ps[j] = rd[7:0];
            end
            check("presc moved", ps[0] !== ps[1], k == 0);
        end
        // Cleared on the execute edge, the prescaler has counted twice when the read is taken
        check("presc cleared", ps[0], 32'h2);
        expect_reg("tick after write", `ALE_ADR_TICK, 32'h1);
        wr(8'h1C, 32'hFF);
        expect_reg("unmapped", 8'h1C, 32'h0);
        wr(`ALE_ADR_ACC, 32'h5A);
        ex(14'h0000);
        expect_reg("acc kept", `ALE_ADR_ACC, 32'h5A);
        // Zero flag is still set from the last AND of the prescaler case
        expect_reg("unsupported", `ALE_ADR_STATUS, 32'h14);
        wr(`ALE_ADR_CONFIG, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        reset_regs();
        results();
    end
endmodule : test_arith_logic_bit_instr_exec
